// [rtl/vme_requester_arbiter.sv]
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RULE1: Slot 0 drives 16 MHz system clock
// RULE2: Grant highest of four pending request levels
// RULE3: Arbiter grants only in Slot 0 role
// RULE4: CLK10 from internal 10 MHz or external
// RULE5: Module-id register drives and reads lines
// RULE6: 32-bit data path, direction by read/write
// RULE7: Strobes frame transfer; acknowledge or error ends
// RULE8: Request bus on mapped remote address
// RULE9: Hold bus request until granted
// RULE10: Controller grants the highest requester
// RULE11: Claim busy first, then drop request
// RULE12: Lock bit keeps ownership across transfers
// RULE13: Remote master sets and clears lock
// RULE14: Unlocked and idle releases bus busy
module vme_requester_arbiter (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Configuration
    input wire logic slot0_i,
    input wire logic clk10_ext_sel_i,
    input wire logic [1:0] req_level_i,
    input wire logic lock_i,
    // Clock pins
    input wire logic external_clock_input_i,
    output logic sysclk_o,
    output logic clk10_o,
    // Arbitration pins
    input wire logic [3:0] br_n_i,
    output logic [3:0] br_n_o,
    output logic [3:0] br_oe_n_o,
    input wire logic [3:0] bgin_n_i,
    output logic [3:0] bgout_n_o,
    input wire logic bbsy_n_i,
    output logic bbsy_n_o,
    output logic bbsy_oe_n_o,
    // Remote access side
    input wire logic map_hit_i,
    input wire logic xfer_req_i,
    input wire logic xfer_write_i,
    input wire logic [1:0] xfer_size_i,
    input wire logic xfer_a0_i,
    input wire logic [31:0] xfer_wdata_i,
    output logic [31:0] xfer_rdata_o,
    output logic xfer_done_o,
    output logic xfer_err_o,
    output logic bus_owned_o,
    // Transfer pins
    output logic as_n_o,
    output logic ds1_n_o,
    output logic ds0_n_o,
    output logic lword_n_o,
    output logic write_n_o,
    output logic ctl_oe_n_o,
    input wire logic dtack_n_i,
    input wire logic berr_n_i,
    input wire logic [31:0] d_i,
    output logic [31:0] d_o,
    output logic d_oe_n_o,
    // Module identification
    input wire logic modid_we_i,
    input wire logic [12:0] modid_wdata_i,
    output logic [12:0] modid_rdata_o,
    input wire logic [12:0] modid_i,
    output logic [12:0] modid_o,
    output logic [12:0] modid_oe_n_o
);

    // ----------------------------------------
    // Clock synthesis
    // ----------------------------------------
    // Fractional accumulators: 250 MHz is no integer multiple of 16 MHz,
    // so edges jitter by one core cycle while the mean rate stays exact.
    logic [8:0] sys_acc_ff, nxt_sys_acc;
    logic [8:0] c10_acc_ff, nxt_c10_acc;
    logic sysclk_ff, nxt_sysclk;
    logic clk10_ff, nxt_clk10;

    always_comb
    begin
        nxt_sys_acc = sys_acc_ff + arb_pkg::SYSCLK_STEP;
        nxt_sysclk = sysclk_ff;
        if (nxt_sys_acc >= arb_pkg::ACC_MOD)
        begin
            nxt_sys_acc = nxt_sys_acc - arb_pkg::ACC_MOD; // see RULE1
            nxt_sysclk = ~sysclk_ff;
        end
        nxt_c10_acc = c10_acc_ff + arb_pkg::CLK10_STEP;
        nxt_clk10 = clk10_ff;
        if (nxt_c10_acc >= arb_pkg::ACC_MOD)
        begin
            nxt_c10_acc = nxt_c10_acc - arb_pkg::ACC_MOD; // see RULE4
            nxt_clk10 = ~clk10_ff;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sys_acc_ff <= arb_pkg::ACC_RST;
            c10_acc_ff <= arb_pkg::ACC_RST;
            sysclk_ff <= 1'b0;
            clk10_ff <= 1'b0;
        end
        else
        begin
            sys_acc_ff <= nxt_sys_acc;
            c10_acc_ff <= nxt_c10_acc;
            sysclk_ff <= nxt_sysclk;
            clk10_ff <= nxt_clk10;
        end
    end

    assign sysclk_o = slot0_i & sysclk_ff; // see RULE1
    assign clk10_o = slot0_i & (clk10_ext_sel_i ? external_clock_input_i : clk10_ff); // see RULE4

    // ----------------------------------------
    // Priority arbiter
    // ----------------------------------------
    arb_pkg::arb_state_t arb_ff, nxt_arb;
    logic [3:0] grant_ff, nxt_grant;
    logic [3:0] pick;
    logic [3:0] req_act;

    assign req_act = ~br_n_i;

    always_comb
    begin
        pick = arb_pkg::GRANT_NONE;
        if (req_act[3])
            pick = 4'h8;
        else if (req_act[2])
            pick = 4'h4;
        else if (req_act[1])
            pick = 4'h2;
        else if (req_act[0])
            pick = 4'h1;
        nxt_arb = arb_ff;
        nxt_grant = grant_ff;
        case (arb_ff)
            arb_pkg::ARB_IDLE:
            begin
                if (slot0_i && bbsy_n_i && |req_act)
                begin
                    nxt_grant = pick; // see RULE2
                    nxt_arb = arb_pkg::ARB_GRANT;
                end
            end
            arb_pkg::ARB_GRANT:
            begin
                // Grant stands until someone claims busy or the granted level drops its request
                if (!bbsy_n_i || !(|(req_act & grant_ff)))
                begin
                    nxt_grant = arb_pkg::GRANT_NONE;
                    nxt_arb = bbsy_n_i ? arb_pkg::ARB_IDLE : arb_pkg::ARB_BUSY;
                end
            end
            arb_pkg::ARB_BUSY:
            begin
                if (bbsy_n_i)
                    nxt_arb = arb_pkg::ARB_IDLE;
            end
            default:
            begin
                nxt_arb = arb_pkg::ARB_IDLE;
                nxt_grant = arb_pkg::GRANT_NONE;
            end
        endcase
        if (!slot0_i)
        begin
            nxt_grant = arb_pkg::GRANT_NONE; // see RULE3
            nxt_arb = arb_pkg::ARB_IDLE;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            arb_ff <= arb_pkg::ARB_IDLE;
            grant_ff <= arb_pkg::GRANT_NONE;
        end
        else
        begin
            arb_ff <= nxt_arb;
            grant_ff <= nxt_grant;
        end
    end

    assign bgout_n_o = ~(grant_ff & {4{slot0_i}}); // see RULE3

    // ----------------------------------------
    // Requester and transfer engine
    // ----------------------------------------
    arb_pkg::req_state_t req_ff, nxt_req;
    arb_pkg::xfer_state_t xf_ff, nxt_xf;
    logic [1:0] lvl_ff, nxt_lvl;
    logic wr_ff, nxt_wr;
    logic [1:0] size_ff, nxt_size;
    logic a0_ff, nxt_a0;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [31:0] rdata_ff, nxt_rdata;
    logic done_ff, nxt_done;
    logic err_ff, nxt_err;
    logic granted;
    logic xf_start;
    logic may_release;

    assign granted = ~bgin_n_i[lvl_ff];
    assign xf_start = (req_ff == arb_pkg::REQ_OWN) && (xf_ff == arb_pkg::XF_IDLE) && xfer_req_i;
    // Lock holds the bus even when no access is pending
    assign may_release = !lock_i && (xf_ff == arb_pkg::XF_IDLE) && !xfer_req_i && !map_hit_i;

    always_comb
    begin
        nxt_req = req_ff;
        nxt_lvl = lvl_ff;
        case (req_ff)
            arb_pkg::REQ_IDLE:
            begin
                if (map_hit_i)
                begin
                    nxt_lvl = req_level_i;
                    nxt_req = arb_pkg::REQ_WAIT; // see RULE8
                end
            end
            arb_pkg::REQ_WAIT:
            begin
                if (granted)
                    nxt_req = arb_pkg::REQ_CLAIM; // see RULE9
            end
            arb_pkg::REQ_CLAIM:
                nxt_req = arb_pkg::REQ_OWN; // see RULE11
            arb_pkg::REQ_OWN:
            begin
                if (may_release)
                    nxt_req = arb_pkg::REQ_IDLE; // see RULE12 see RULE14
            end
            default:
                nxt_req = arb_pkg::REQ_IDLE;
        endcase
    end

    always_comb
    begin
        nxt_xf = xf_ff;
        nxt_wr = wr_ff;
        nxt_size = size_ff;
        nxt_a0 = a0_ff;
        nxt_wdata = wdata_ff;
        nxt_rdata = rdata_ff;
        nxt_err = err_ff;
        nxt_done = 1'b0;
        case (xf_ff)
            arb_pkg::XF_IDLE:
            begin
                if (xf_start)
                begin
                    nxt_wr = xfer_write_i; // see RULE6
                    nxt_size = xfer_size_i;
                    nxt_a0 = xfer_a0_i;
                    nxt_wdata = xfer_wdata_i;
                    nxt_xf = arb_pkg::XF_STROBE;
                end
            end
            arb_pkg::XF_STROBE:
            begin
                if (!dtack_n_i || !berr_n_i)
                begin
                    nxt_err = !berr_n_i; // see RULE7
                    if (!wr_ff)
                        nxt_rdata = d_i;
                    nxt_xf = arb_pkg::XF_RELEASE;
                end
            end
            arb_pkg::XF_RELEASE:
            begin
                // Wait for the slave to lift its answer before the next cycle
                if (dtack_n_i && berr_n_i)
                begin
                    nxt_done = 1'b1;
                    nxt_xf = arb_pkg::XF_IDLE;
                end
            end
            default:
                nxt_xf = arb_pkg::XF_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            req_ff <= arb_pkg::REQ_IDLE;
            xf_ff <= arb_pkg::XF_IDLE;
            lvl_ff <= 2'h0;
            wr_ff <= 1'b0;
            size_ff <= arb_pkg::SIZE_8;
            a0_ff <= 1'b0;
            wdata_ff <= arb_pkg::DATA_RST;
            rdata_ff <= arb_pkg::DATA_RST;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
        end
        else
        begin
            req_ff <= nxt_req;
            xf_ff <= nxt_xf;
            lvl_ff <= nxt_lvl;
            wr_ff <= nxt_wr;
            size_ff <= nxt_size;
            a0_ff <= nxt_a0;
            wdata_ff <= nxt_wdata;
            rdata_ff <= nxt_rdata;
            done_ff <= nxt_done;
            err_ff <= nxt_err;
        end
    end

    logic strobe;
    assign strobe = (xf_ff == arb_pkg::XF_STROBE);

    assign br_n_o = 4'h0;
    assign br_oe_n_o = ~(((req_ff == arb_pkg::REQ_WAIT) || (req_ff == arb_pkg::REQ_CLAIM))
                         ? (4'h1 << lvl_ff) : 4'h0); // see RULE9 see RULE11
    assign bbsy_n_o = 1'b0;
    assign bbsy_oe_n_o = ~((req_ff == arb_pkg::REQ_CLAIM) || (req_ff == arb_pkg::REQ_OWN));
    assign bus_owned_o = (req_ff == arb_pkg::REQ_OWN);
    assign ctl_oe_n_o = ~bus_owned_o;
    assign as_n_o = ~strobe; // see RULE7
    assign ds1_n_o = ~(strobe && ((size_ff != arb_pkg::SIZE_8) || !a0_ff));
    assign ds0_n_o = ~(strobe && ((size_ff != arb_pkg::SIZE_8) || a0_ff));
    assign lword_n_o = ~(size_ff == arb_pkg::SIZE_32);
    assign write_n_o = ~wr_ff;
    assign d_o = wdata_ff;
    assign d_oe_n_o = ~(strobe && wr_ff); // see RULE6
    assign xfer_rdata_o = rdata_ff;
    assign xfer_done_o = done_ff;
    assign xfer_err_o = err_ff;

    // ----------------------------------------
    // Module identification
    // ----------------------------------------
    logic [12:0] modid_ff, nxt_modid;
    logic [12:0] modid_rd_ff, nxt_modid_rd;

    always_comb
    begin
        nxt_modid = modid_ff;
        if (modid_we_i && slot0_i)
            nxt_modid = modid_wdata_i; // see RULE5
        nxt_modid_rd = modid_i;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            modid_ff <= arb_pkg::MODID_RST;
            modid_rd_ff <= arb_pkg::MODID_RST;
        end
        else
        begin
            modid_ff <= nxt_modid;
            modid_rd_ff <= nxt_modid_rd;
        end
    end

    // A set bit pulls its line low; pins stay released outside Slot 0
    assign modid_o = 13'h0000;
    assign modid_oe_n_o = ~(modid_ff & {13{slot0_i}}); // see RULE5
    assign modid_rdata_o = modid_rd_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence claim_then_drop_s;
        (!bbsy_oe_n_o && !br_oe_n_o[lvl_ff]) ##1 (!bbsy_oe_n_o && br_oe_n_o[lvl_ff]);
    endsequence

    grant_off_slot_a: assert property (!slot0_i |-> bgout_n_o == 4'hf) // see RULE3
        else $error("grant driven outside slot 0");
    grant_prio_a: assert property ((arb_ff == arb_pkg::ARB_IDLE && slot0_i && bbsy_n_i
        && |req_act) |=> ~bgout_n_o == $past(pick)) // see RULE2
        else $error("grant not to highest requester");
    req_on_hit_a: assert property ((req_ff == arb_pkg::REQ_IDLE && map_hit_i)
        |=> br_oe_n_o != 4'hf) // see RULE8
        else $error("no bus request on mapped hit");
    req_hold_a: assert property ((req_ff == arb_pkg::REQ_WAIT && !granted)
        |=> !br_oe_n_o[lvl_ff]) // see RULE9
        else $error("bus request dropped before grant");
    claim_order_a: assert property ((req_ff == arb_pkg::REQ_WAIT && granted)
        |=> claim_then_drop_s) // see RULE11
        else $error("busy not claimed before request drop");
    lock_keep_a: assert property ((bus_owned_o && lock_i) |=> !bbsy_oe_n_o) // see RULE12
        else $error("bus released while locked");
    idle_release_a: assert property ((bus_owned_o && may_release) |=> bbsy_oe_n_o) // see RULE14
        else $error("busy kept while idle and unlocked");
    xfer_frame_a: assert property (xf_start |=> (!as_n_o && d_oe_n_o == !$past(xfer_write_i))
        ##1 !as_n_o [*1] ##0 (strobe)) // see RULE6
        else $error("transfer strobes or direction wrong");
    xfer_end_a: assert property ((strobe && !berr_n_i) |=> as_n_o && xfer_err_o) // see RULE7
        else $error("bus error not reported");
    // Leaving the Slot 0 role parks the clocks low, so no edge is owed then
    sysclk_run_a: assert property (slot0_i [*8]
        |-> ##[1:8] ($changed(sysclk_o) || !slot0_i)) // see RULE1
        else $error("system clock stalled");
    clk10_int_a: assert property ((slot0_i && !clk10_ext_sel_i) [*8]
        |-> ##[1:13] ($changed(clk10_o) || !slot0_i || clk10_ext_sel_i)) // see RULE4
        else $error("internal clk10 stalled");
    modid_wr_a: assert property ((modid_we_i && slot0_i) ##1 slot0_i
        |-> modid_oe_n_o == ~$past(modid_wdata_i)) // see RULE5
        else $error("module id not driven as written");

endmodule // vme_requester_arbiter

`default_nettype wire

// [rtl/arb_pkg.sv]
package arb_pkg;

    // ----------------------------------------
    // Clock rates
    // ----------------------------------------
    localparam int CORE_MHZ = 250;
    localparam int SYSCLK_MHZ = 16;
    localparam int CLK10_MHZ = 10;
    // Oscillator tolerance in ppm, inherited from the core clock source
    localparam int OSC_PPM = 100;
    localparam logic [8:0] ACC_MOD = 9'(CORE_MHZ);
    localparam logic [8:0] SYSCLK_STEP = 9'(2 * SYSCLK_MHZ);
    localparam logic [8:0] CLK10_STEP = 9'(2 * CLK10_MHZ);
    localparam logic [8:0] ACC_RST = 9'h000;

    // ----------------------------------------
    // Widths and reset values
    // ----------------------------------------
    localparam int LEVELS = 4;
    localparam int MODID_W = 13;
    localparam int DATA_W = 32;
    localparam logic [MODID_W-1:0] MODID_RST = 13'h0000;
    localparam logic [LEVELS-1:0] GRANT_NONE = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

    // ----------------------------------------
    // Transfer size codes
    // ----------------------------------------
    localparam logic [1:0] SIZE_8 = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;
    localparam logic [1:0] SIZE_32 = 2'h2;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_GRANT = 2'b01,
        ARB_BUSY = 2'b10
    } arb_state_t;

    typedef enum logic [1:0] {
        REQ_IDLE = 2'b00,
        REQ_WAIT = 2'b01,
        REQ_CLAIM = 2'b10,
        REQ_OWN = 2'b11
    } req_state_t;

    typedef enum logic [1:0] {
        XF_IDLE = 2'b00,
        XF_STROBE = 2'b01,
        XF_RELEASE = 2'b10
    } xfer_state_t;

endpackage

// [tb/vme_far_model.sv]
`timescale 1ns/10ps
`default_nettype none
module vme_far_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Arbitration lines
    input wire logic [1:0] level_i,
    input wire logic [3:0] br_n_i,
    input wire logic bbsy_n_i,
    output logic [3:0] bgin_n_o,
    // Slave side
    input wire logic as_n_i,
    input wire logic ds1_n_i,
    input wire logic ds0_n_i,
    input wire logic write_n_i,
    input wire logic [31:0] rdata_i,
    input wire logic err_i,
    input wire logic [2:0] wait_i,
    output logic dtack_n_o,
    output logic berr_n_o,
    output logic [31:0] d_o
);
    logic [2:0] cnt_ff;
    logic [31:0] last_ff;

    // Grant pulled as soon as busy is claimed, no courtesy hold
    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            bgin_n_o <= 4'hf;
        else if (!bbsy_n_i || br_n_i[level_i])
            bgin_n_o <= 4'hf;
        else
            bgin_n_o <= ~(4'h1 << level_i);
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_ff <= 3'h0;
            dtack_n_o <= 1'b1;
            berr_n_o <= 1'b1;
            last_ff <= 32'h0;
        end
        else
        begin
            last_ff <= d_o;
            if (as_n_i || (ds1_n_i && ds0_n_i))
            begin
                cnt_ff <= 3'h0;
                dtack_n_o <= 1'b1;
                berr_n_o <= 1'b1;
            end
            else if (cnt_ff == wait_i)
            begin
                dtack_n_o <= err_i;
                berr_n_o <= !err_i;
            end
            else
                cnt_ff <= cnt_ff + 3'h1;
        end
    end

    // Released data toggles so a stale sample never looks valid
    assign d_o = (!as_n_i && write_n_i) ? rdata_i : ~last_ff;
endmodule // vme_far_model
`default_nettype wire

// [tb/vme_requester_arbiter_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module vme_requester_arbiter_bench;
    localparam int LIMIT = 10000;
    logic core_clk_i = 1'b0, arst_n_i = 1'b0, slot0_i = 1'b0, clk10_ext_sel_i = 1'b0;
    logic lock_i = 1'b0, external_clock_input_i = 1'b0, map_hit_i = 1'b0, xfer_req_i = 1'b0;
    logic xfer_write_i = 1'b0, xfer_a0_i = 1'b0, modid_we_i = 1'b0, oth_bbsy = 1'b1;
    logic [1:0] req_level_i = 2'h0, xfer_size_i = 2'h0;
    logic [31:0] xfer_wdata_i = 32'h0, rd_val = 32'h0, mdl_d, d_i, d_o, xfer_rdata_o;
    logic [12:0] modid_wdata_i = 13'h0, mod_ext = 13'h1fff, v, ev;
    logic [12:0] modid_i, modid_o, modid_oe_n_o, modid_rdata_o;
    logic [3:0] oth_br = 4'hf, m, br_n_i, br_n_o, br_oe_n_o, bgin_n_i, bgout_n_o, mdl_bg;
    logic err_mode = 1'b0, bbsy_n_i, bbsy_n_o, bbsy_oe_n_o, sysclk_o, clk10_o;
    logic xfer_done_o, xfer_err_o, bus_owned_o, as_n_o, ds1_n_o, ds0_n_o, lword_n_o;
    logic write_n_o, ctl_oe_n_o, dtack_n_i, berr_n_i, d_oe_n_o;
    logic [2:0] wait_cyc = 3'h0;
    int seed = 91;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int ns, nc;

    // ----------------------------------------
    // Wired lines
    // ----------------------------------------
    assign br_n_i = br_oe_n_o & oth_br;
    assign bbsy_n_i = bbsy_oe_n_o & oth_bbsy;
    assign bgin_n_i = slot0_i ? bgout_n_o : mdl_bg;
    assign modid_i = modid_oe_n_o & mod_ext;
    assign d_i = d_oe_n_o ? mdl_d : d_o;

    vme_requester_arbiter dut_u (
        .core_clk_i, .arst_n_i, .slot0_i, .clk10_ext_sel_i, .req_level_i, .lock_i,
        .external_clock_input_i, .sysclk_o, .clk10_o, .br_n_i, .br_n_o, .br_oe_n_o,
        .bgin_n_i, .bgout_n_o, .bbsy_n_i, .bbsy_n_o, .bbsy_oe_n_o, .map_hit_i, .xfer_req_i,
        .xfer_write_i, .xfer_size_i, .xfer_a0_i, .xfer_wdata_i, .xfer_rdata_o, .xfer_done_o,
        .xfer_err_o, .bus_owned_o, .as_n_o, .ds1_n_o, .ds0_n_o, .lword_n_o, .write_n_o,
        .ctl_oe_n_o, .dtack_n_i, .berr_n_i, .d_i, .d_o, .d_oe_n_o, .modid_we_i,
        .modid_wdata_i, .modid_rdata_o, .modid_i, .modid_o, .modid_oe_n_o
    );

    vme_far_model far_u (
        .clk_i(core_clk_i), .arst_n_i(arst_n_i), .level_i(req_level_i), .br_n_i(br_n_i),
        .bbsy_n_i(bbsy_n_i), .bgin_n_o(mdl_bg), .as_n_i(as_n_o), .ds1_n_i(ds1_n_o),
        .ds0_n_i(ds0_n_o), .write_n_i(write_n_o), .rdata_i(rd_val), .err_i(err_mode),
        .wait_i(wait_cyc), .dtack_n_o(dtack_n_i), .berr_n_o(berr_n_i), .d_o(mdl_d)
    );

    always #2 core_clk_i = ~core_clk_i;

    always @(posedge core_clk_i)
    begin
        cycles = cycles + 1;
        if (cycles == LIMIT)
        begin
            failures = failures + 1;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares = compares + 1;
        if (seen !== want)
        begin
            failures = failures + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    function automatic logic [3:0] highest(input logic [3:0] r);
        highest = 4'h0;
        for (int k = 0; k < 4; k++)
            if (r[k])
                highest = 4'h1 << k;
    endfunction

    // Expected {lword, ds1, ds0}, all active low
    function automatic logic [2:0] lanes(input logic [1:0] sz, input logic a0);
        if (sz == arb_pkg::SIZE_32)
            lanes = 3'h0;
        else if (sz != arb_pkg::SIZE_8)
            lanes = 3'h4;
        else
            lanes = a0 ? 3'h6 : 3'h5;
    endfunction

    task automatic xfer(input logic w, input logic [1:0] sz, input logic a0, input logic e);
        logic [31:0] wd;
        logic [2:0] ln;
        logic seen;
        int n;
        wd = $random(seed);
        rd_val = $random(seed);
        wait_cyc = 3'($random(seed));
        err_mode = e;
        xfer_write_i = w;
        xfer_size_i = sz;
        xfer_a0_i = a0;
        xfer_wdata_i = wd;
        xfer_req_i = 1'b1;
        seen = 1'b0;
        ln = 3'h7;
        for (n = 0; n < 40 && xfer_done_o !== 1'b1; n++)
        begin
            tick(1);
            if (as_n_o === 1'b0 && !seen)
            begin
                seen = 1'b1;
                ln = {lword_n_o, ds1_n_o, ds0_n_o};
                check(write_n_o, !w);
                check(d_oe_n_o, !w);
                if (w)
                    check(d_o, wd);
            end
        end
        xfer_req_i = 1'b0;
        check(xfer_done_o, 1'b1);
        check(ln, lanes(sz, a0));
        check(xfer_err_o, e);
        if (!w && !e)
            check(xfer_rdata_o, rd_val);
        tick(1);
        check(xfer_done_o, 1'b0);
    endtask

    task automatic count_edges(output int cs, output int cc);
        logic ps, pc;
        tick(1);
        cs = 0;
        cc = 0;
        ps = sysclk_o;
        pc = clk10_o;
        repeat (1000)
        begin
            tick(1);
            cs += (sysclk_o === 1'b1 && ps === 1'b0);
            cc += (clk10_o === 1'b1 && pc === 1'b0);
            ps = sysclk_o;
            pc = clk10_o;
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        tick(20);
        arst_n_i = 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            slot0_i = (i < 9);
            m = (i < 4) ? 4'h1 << i : 4'($random(seed));
            oth_br = ~m;
            tick(2);
            check(bgout_n_o, 4'(slot0_i ? ~highest(m) : 4'hf));
            oth_bbsy = 1'b0;
            oth_br = 4'hf;
            tick(2);
            check(bgout_n_o, 4'hf);
            oth_bbsy = 1'b1;
            tick(2);
        end
        $display("test arbiter finished");
        for (int s = 0; s < 2; s++)
        begin
            slot0_i = s[0];
            req_level_i = 2'($random(seed));
            lock_i = 1'b1;
            map_hit_i = 1'b1;
            tick(2);
            check(br_oe_n_o, 4'(~(4'h1 << req_level_i)));
            for (int n = 0; n < 20 && bus_owned_o !== 1'b1; n++)
                tick(1);
            check(bbsy_oe_n_o, 1'b0);
            check({ctl_oe_n_o, bbsy_n_o, br_n_o}, 6'h00);
            check(br_oe_n_o, 4'hf);
            map_hit_i = 1'b0;
            for (int t = 0; t < 6; t++)
                xfer(1'($random(seed)), 2'($random(seed)), 1'($random(seed)), t == 3);
            tick(3);
            check(bus_owned_o, 1'b1);
            lock_i = 1'b0;
            tick(3);
            check(bbsy_oe_n_o, 1'b1);
            check(ctl_oe_n_o, 1'b1);
        end
        $display("test requester finished");
        for (int i = 0; i < 6; i++)
        begin
            slot0_i = (i < 4);
            v = 13'($random(seed));
            mod_ext = 13'($random(seed));
            ev = slot0_i ? ~v : 13'h1fff;
            modid_wdata_i = v;
            modid_we_i = 1'b1;
            tick(1);
            modid_we_i = 1'b0;
            tick(2);
            check(modid_oe_n_o, ev);
            check(modid_rdata_o, ev & mod_ext);
            check(modid_o, 13'h0000);
        end
        $display("test modid finished");
        slot0_i = 1'b1;
        count_edges(ns, nc);
        check(ns >= 63 && ns <= 65, 1'b1);
        check(nc >= 39 && nc <= 41, 1'b1);
        clk10_ext_sel_i = 1'b1;
        repeat (8)
        begin
            external_clock_input_i = 1'($random(seed));
            #1;
            check(clk10_o, external_clock_input_i);
            tick(1);
        end
        slot0_i = 1'b0;
        clk10_ext_sel_i = 1'b0;
        count_edges(ns, nc);
        check(ns + nc, 0);
        $display("test clocks finished");
        wrap_up();
    end
endmodule // vme_requester_arbiter_bench
`default_nettype wire
